// >>> rtl/sat_cfg.svh
`ifndef SAT_CFG_SVH
`define SAT_CFG_SVH

// Register byte offsets on the APB window.
`define SAT_OFF_CTRL        12'h000
`define SAT_OFF_STATUS      12'h004
`define SAT_OFF_TXBUF       12'h008
`define SAT_OFF_RXBUF       12'h00C
`define SAT_OFF_DIV         12'h010

// Control register layout: the low bits carry the control struct.
`define SAT_CTRL_WIDTH      9
`define SAT_CTRL_RESET      9'h000

// Status register bit positions.
`define SAT_ST_TXFLAG       0
`define SAT_ST_SHIFT_IDLE   1
`define SAT_ST_RXFLAG       2
`define SAT_ST_RXFULL       3
`define SAT_ST_OVERRUN      4

// Character and divider widths and reset values.
`define SAT_CHAR_WIDTH      9
`define SAT_DIV_WIDTH       16
`define SAT_DIV_RESET       16'h0019

// Bits left after the start bit: data bits plus one stop bit; the receive values count data bits only.
`define SAT_TX_LEFT8        4'h9
`define SAT_TX_LEFT9        4'hA
`define SAT_RX_BITS8        4'h8
`define SAT_RX_BITS9        4'h9

`endif

// >>> rtl/sat_pkg.sv
package sat_pkg;

   // Bit 0 is serial_port_enable, bit 8 is transmit_interrupt_enable.
   typedef struct packed {
      logic transmit_interrupt_enable;
      logic wide_divider;
      logic continuous_receive_enable;
      logic single_receive_enable;
      logic line_polarity_select;
      logic nine_bit;
      logic sync_mode;
      logic transmit_enable;
      logic serial_port_enable;
   } sat_ctrl_type;

   typedef enum logic [1:0] {
      SAT_TX_IDLE  = 2'h0,
      SAT_TX_SHIFT = 2'h1
   } sat_tx_state_type;

   typedef enum logic [1:0] {
      SAT_RX_IDLE  = 2'h0,
      SAT_RX_LEAD  = 2'h1,
      SAT_RX_TRAIL = 2'h3
   } sat_rx_state_type;

   typedef struct packed {
      sat_ctrl_type     ctrl;
      logic [15:0]      div;
      logic [8:0]       tx_buf;
      logic             tx_buf_full;
      sat_tx_state_type tx_state;
      logic [9:0]       tx_shift;
      logic [3:0]       tx_left;
      logic             tx_line;
      logic             txflag;
      logic             txflag_hold;
      sat_rx_state_type rx_state;
      logic [8:0]       rx_shift;
      logic [3:0]       rx_count;
      logic             overrun;
      logic             clock_pin;
      logic [31:0]      rdata;
   } sat_core_type;

endpackage

// >>> rtl/sat_baud.sv
`timescale 1ns/10ps
`include "sat_cfg.svh"

// Bit-rate divider: one tick every divisor+1 clocks (only its low byte unless wide), phase reset by restart.
module sat_baud #(
   parameter int WIDTH = `SAT_DIV_WIDTH
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             restart,
   input  wire logic             wide,
   input  wire logic [WIDTH-1:0] divisor,
   output logic                  tick
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
   } sat_baud_state_type;

   sat_baud_state_type s;
   sat_baud_state_type next_s;
   logic [WIDTH-1:0]   limit;

   always_comb begin
      next_s = s;
      limit  = wide ? divisor : {{(WIDTH-8){1'b0}}, divisor[7:0]};
      if (restart || s.count >= limit) begin
         next_s.count = '0;
      end else begin
         next_s.count = s.count + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = (s.count >= limit);

endmodule

// >>> rtl/sat_rx_fifo.sv
`timescale 1ns/10ps

// Small receive FIFO; a push into a full FIFO without a pop in the same cycle is dropped and reported.
module sat_rx_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   input  wire logic             pop,
   output logic [WIDTH-1:0]      head,
   output logic                  empty,
   output logic                  full,
   output logic                  dropped
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               rd;
      logic [PW-1:0]               wr;
      logic [CW-1:0]               count;
   } sat_fifo_state_type;

   sat_fifo_state_type s;
   sat_fifo_state_type next_s;
   logic               do_pop;
   logic               do_push;

   always_comb begin
      next_s  = s;
      do_pop  = pop && (s.count != '0);
      do_push = push && ((s.count != CW'(DEPTH)) || do_pop);
      if (do_pop) begin
         next_s.rd = (s.rd == PW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
      end
      if (do_push) begin
         next_s.mem[s.wr] = push_data;
         next_s.wr = (s.wr == PW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
      end
      if (do_push && !do_pop) begin
         next_s.count = s.count + 1'b1;
      end else if (do_pop && !do_push) begin
         next_s.count = s.count - 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign head    = s.mem[s.rd];
   assign empty   = (s.count == '0);
   assign full    = (s.count == CW'(DEPTH));
   assign dropped = push && !do_push;

endmodule

// >>> rtl/sat_core.sv
// Contract
// - Idle transmit line rests at mark, a logic one.
// - Frame is start space, eight or nine data bits, mark stop bit.
// - Every transmitted bit lasts exactly one baud period.
// - Baud timing from a divider, 8-bit or 16-bit wide.
// - Data bits travel least significant bit first, both directions.
// - Transmitter and receiver independent, shared format and rate, no parity.
// - Shift register loads only from the buffer, invisible to software.
// - Async transmit runs only with transmit, port enable set, sync clear.
// - Port enable alone makes the clock/transmit pin an output.
// - Buffer-empty flag sets as soon as transmit enable is set.
// - Buffer write starts sending; idle shift register loads immediately.
// - Busy shifter: buffer waits until stop bit ends, then start follows.
// - Async polarity select zero gives high-true line, one inverts it.
// - Flag set when enabled with empty buffer, else clear.
// - Flag reflects a buffer write from the second cycle after it.
// - Flag read-only, independent of the interrupt enable gating.
// - Synchronous master receive never drives the data pin.
// - Single receive clocks one character then clears itself.
// - Continuous receive clocks until cleared; clearing discards partial data.
// - Data pin sampled on trailing edge of generated clock.
// - Completed character enters two-entry FIFO and raises receive flag.
// - Receive enables take priority over transmit in synchronous mode.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/10ps
`include "sat_cfg.svh"

module sat_core #(
   parameter int FIFO_DEPTH = 2,
   parameter int DIV_WIDTH  = `SAT_DIV_WIDTH
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             transmit_clock_pin_o,
   output logic             transmit_clock_pin_oe,
   input  wire logic        receive_data_pin_i,
   output logic             receive_data_pin_o,
   output logic             receive_data_pin_oe,
   output logic             transmit_request
);

   sat_pkg::sat_core_type s;
   sat_pkg::sat_core_type next_s;

   logic                           setup;
   logic                           access;
   logic                           mapped;
   logic                           tx_on;
   logic                           rx_on;
   logic                           tx_load;
   logic                           tx_tick;
   logic                           rx_tick;
   logic                           rx_push;
   logic [`SAT_CHAR_WIDTH-1:0]     rx_char;
   logic [3:0]                     rx_bits;
   logic [3:0]                     rx_next_count;
   logic                           rx_pop;
   logic [`SAT_CHAR_WIDTH-1:0]     rx_head;
   logic                           rx_empty;
   logic                           rx_full;
   logic                           rx_dropped;
   logic [31:0]                    status_word;

   // The transmitter has its own divider so that a load restarts the bit phase.
   sat_baud #(
      .WIDTH   (DIV_WIDTH)
   ) u_tx_baud (
      .pclk    (pclk),
      .presetn (presetn),
      .restart (tx_load || !tx_on),
      .wide    (s.ctrl.wide_divider),
      .divisor (s.div),
      .tick    (tx_tick)
   );

   sat_baud #(
      .WIDTH   (DIV_WIDTH)
   ) u_rx_baud (
      .pclk    (pclk),
      .presetn (presetn),
      .restart (!rx_on),
      .wide    (s.ctrl.wide_divider),
      .divisor (s.div),
      .tick    (rx_tick)
   );

   sat_rx_fifo #(
      .WIDTH     (`SAT_CHAR_WIDTH),
      .DEPTH     (FIFO_DEPTH)
   ) u_rx_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .push      (rx_push),
      .push_data (rx_char),
      .pop       (rx_pop),
      .head      (rx_head),
      .empty     (rx_empty),
      .full      (rx_full),
      .dropped   (rx_dropped)
   );

   always_comb begin
      setup  = psel && !penable;
      access = psel && penable;
      mapped = 1'b0;
      if (paddr == `SAT_OFF_CTRL) begin
         mapped = 1'b1;
      end else if (paddr == `SAT_OFF_STATUS) begin
         mapped = 1'b1;
      end else if (paddr == `SAT_OFF_TXBUF) begin
         mapped = 1'b1;
      end else if (paddr == `SAT_OFF_RXBUF) begin
         mapped = 1'b1;
      end else if (paddr == `SAT_OFF_DIV) begin
         mapped = 1'b1;
      end
   end

   assign pready  = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata  = s.rdata;

   // Reading the receive buffer in the access phase retires the oldest entry.
   assign rx_pop = access && !pwrite && (paddr == `SAT_OFF_RXBUF);

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`SAT_ST_TXFLAG]     = s.txflag;
      status_word[`SAT_ST_SHIFT_IDLE] = (s.tx_state == sat_pkg::SAT_TX_IDLE);
      status_word[`SAT_ST_RXFLAG]     = !rx_empty;
      status_word[`SAT_ST_RXFULL]     = rx_full;
      status_word[`SAT_ST_OVERRUN]    = s.overrun;
   end

   always_comb begin
      next_s        = s;
      tx_load       = 1'b0;
      rx_push       = 1'b0;
      rx_char       = '0;
      rx_next_count = s.rx_count + 4'h1;
      tx_on = s.ctrl.serial_port_enable && s.ctrl.transmit_enable
              && !s.ctrl.sync_mode;
      // In synchronous mode only the receive enables run the engine.
      rx_on = s.ctrl.serial_port_enable && s.ctrl.sync_mode
              && (s.ctrl.single_receive_enable
                  || s.ctrl.continuous_receive_enable);
      rx_bits = s.ctrl.nine_bit ? `SAT_RX_BITS9 : `SAT_RX_BITS8;

      // Asynchronous transmitter.
      if (!tx_on) begin
         next_s.tx_state = sat_pkg::SAT_TX_IDLE;
         next_s.tx_line  = 1'b1;
      end else begin
         case (s.tx_state)
            sat_pkg::SAT_TX_IDLE: begin
               tx_load = s.tx_buf_full;
            end
            sat_pkg::SAT_TX_SHIFT: begin
               if (tx_tick) begin
                  if (s.tx_left == 4'h0) begin
                     // Stop bit done: a waiting character follows at once.
                     next_s.tx_state = sat_pkg::SAT_TX_IDLE;
                     next_s.tx_line  = 1'b1;
                     tx_load         = s.tx_buf_full;
                  end else begin
                     next_s.tx_line  = s.tx_shift[0];
                     next_s.tx_shift = {1'b1, s.tx_shift[9:1]};
                     next_s.tx_left  = s.tx_left - 4'h1;
                  end
               end
            end
            default: begin
               next_s.tx_state = sat_pkg::SAT_TX_IDLE;
            end
         endcase
      end

      if (tx_load) begin
         // The shifter is filled from the buffer and nowhere else.
         next_s.tx_state    = sat_pkg::SAT_TX_SHIFT;
         next_s.tx_line     = 1'b0;
         next_s.tx_buf_full = 1'b0;
         if (s.ctrl.nine_bit) begin
            next_s.tx_shift = {1'b1, s.tx_buf};
            next_s.tx_left  = `SAT_TX_LEFT9;
         end else begin
            next_s.tx_shift = {2'b11, s.tx_buf[7:0]};
            next_s.tx_left  = `SAT_TX_LEFT8;
         end
      end

      // Synchronous master receiver.
      if (!rx_on) begin
         // Dropping the enables parks the clock and throws away partial bits.
         next_s.rx_state = sat_pkg::SAT_RX_IDLE;
         next_s.rx_count = 4'h0;
      end else begin
         case (s.rx_state)
            sat_pkg::SAT_RX_IDLE: begin
               if (rx_tick) begin
                  next_s.rx_state = sat_pkg::SAT_RX_LEAD;
               end
            end
            sat_pkg::SAT_RX_LEAD: begin
               if (rx_tick) begin
                  next_s.rx_state = sat_pkg::SAT_RX_TRAIL;
                  next_s.rx_shift = {receive_data_pin_i, s.rx_shift[8:1]};
                  next_s.rx_count = rx_next_count;
                  if (rx_next_count == rx_bits) begin
                     rx_push         = 1'b1;
                     next_s.rx_count = 4'h0;
                     // Single receive ends itself; continuous then carries on.
                     next_s.ctrl.single_receive_enable = 1'b0;
                  end
               end
            end
            sat_pkg::SAT_RX_TRAIL: begin
               if (rx_tick) begin
                  next_s.rx_state = sat_pkg::SAT_RX_LEAD;
               end
            end
            default: begin
               next_s.rx_state = sat_pkg::SAT_RX_IDLE;
            end
         endcase
      end

      // The first bit received sits lowest, whatever the character length.
      if (s.ctrl.nine_bit) begin
         rx_char = next_s.rx_shift;
      end else begin
         rx_char = {1'b0, next_s.rx_shift[8:1]};
      end

      // Software writes come last so that a written enable wins over hardware.
      next_s.txflag_hold = 1'b0;
      if (access && pwrite) begin
         if (paddr == `SAT_OFF_CTRL) begin
            next_s.ctrl = sat_pkg::sat_ctrl_type'(pwdata[`SAT_CTRL_WIDTH-1:0]);
         end else if (paddr == `SAT_OFF_DIV) begin
            next_s.div = pwdata[15:0];
         end else if (paddr == `SAT_OFF_TXBUF) begin
            next_s.tx_buf      = pwdata[8:0];
            next_s.tx_buf_full = 1'b1;
            next_s.txflag_hold = 1'b1;
         end else if (paddr == `SAT_OFF_STATUS) begin
            if (pwdata[`SAT_ST_OVERRUN]) begin
               next_s.overrun = 1'b0;
            end
         end
      end
      if (rx_dropped) begin
         next_s.overrun = 1'b1;
      end

      // The flag is not software writable and lags a buffer write by two cycles.
      if (!s.txflag_hold) begin
         next_s.txflag = s.ctrl.transmit_enable && !s.tx_buf_full;
      end

      // Pin level: data with polarity in async, generated clock in sync.
      if (next_s.ctrl.sync_mode) begin
         next_s.clock_pin = next_s.ctrl.line_polarity_select
                            ^ (next_s.rx_state == sat_pkg::SAT_RX_LEAD);
      end else begin
         next_s.clock_pin = next_s.tx_line ^ next_s.ctrl.line_polarity_select;
      end

      // Read data is captured in the setup phase and shown in the access phase.
      if (setup && !pwrite) begin
         if (paddr == `SAT_OFF_CTRL) begin
            next_s.rdata = {{(32-`SAT_CTRL_WIDTH){1'b0}}, s.ctrl};
         end else if (paddr == `SAT_OFF_STATUS) begin
            next_s.rdata = status_word;
         end else if (paddr == `SAT_OFF_TXBUF) begin
            next_s.rdata = {23'h000000, s.tx_buf};
         end else if (paddr == `SAT_OFF_RXBUF) begin
            next_s.rdata = {23'h000000, rx_empty ? 9'h000 : rx_head};
         end else if (paddr == `SAT_OFF_DIV) begin
            next_s.rdata = {16'h0000, s.div};
         end else begin
            next_s.rdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s              <= '0;
         s.ctrl         <= `SAT_CTRL_RESET;
         s.div          <= `SAT_DIV_RESET;
         s.tx_line      <= 1'b1;
         s.clock_pin    <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign transmit_clock_pin_o  = s.clock_pin;
   assign transmit_clock_pin_oe = s.ctrl.serial_port_enable;
   // Only master receive is built here, so the data pin is never driven.
   assign receive_data_pin_o    = 1'b0;
   assign receive_data_pin_oe   = 1'b0;
   // The enable gates only the request, never the flag itself.
   assign transmit_request = s.txflag && s.ctrl.transmit_interrupt_enable;

endmodule

// >>> dv/sat_sva.sv
`timescale 1ns/10ps
`include "sat_cfg.svh"

module sat_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        transmit_clock_pin_o,
   input wire logic        transmit_clock_pin_oe,
   input wire logic        receive_data_pin_i,
   input wire logic        receive_data_pin_o,
   input wire logic        receive_data_pin_oe,
   input wire logic        transmit_request
);
   // Control and divider are shadowed from bus writes.
   sat_pkg::sat_ctrl_type c;
   logic [15:0]           dv;
   logic [16:0]           run;
   logic                  pin_d;
   logic                  wr;
   logic [16:0]           per;
   logic                  lvl;
   logic                  edge_seen;
   logic                  tx_on;
   logic                  rx_on;
   logic                  quiet;
   assign wr        = psel && penable && pready && pwrite;
   assign per       = (c.wide_divider ? {1'b0, dv} : {9'h000, dv[7:0]}) + 17'h00001;
   assign lvl       = transmit_clock_pin_o ^ c.line_polarity_select;
   assign edge_seen = transmit_clock_pin_o != pin_d;
   assign tx_on     = c.serial_port_enable && c.transmit_enable && !c.sync_mode;
   assign quiet     = c.serial_port_enable && c.sync_mode && !c.single_receive_enable
                      && !c.continuous_receive_enable;
   assign rx_on     = c.serial_port_enable && c.sync_mode && !quiet && !c.line_polarity_select;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c     <= 9'h000;
         dv    <= `SAT_DIV_RESET;
         run   <= 17'h00001;
         pin_d <= 1'b1;
      end else begin
         if (wr && paddr == `SAT_OFF_CTRL) c <= pwdata[8:0];
         if (wr && paddr == `SAT_OFF_DIV) dv <= pwdata[15:0];
         pin_d <= transmit_clock_pin_o;
         run   <= edge_seen ? 17'h00001 : run + 17'h00001;
      end
   end

   default clocking dcb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_rx_undriven: assert property (!receive_data_pin_oe)
      else $error("data pin driven during receive");
   a_pin_enable: assert property (transmit_clock_pin_oe == c.serial_port_enable)
      else $error("clock pin enable differs from port enable");
   a_req_gate: assert property (transmit_request |-> c.transmit_interrupt_enable)
      else $error("request raised without interrupt enable");
   a_flag_hold: assert property (wr && paddr == `SAT_OFF_TXBUF |-> ##2 $stable(transmit_request))
      else $error("flag moved in the cycle after a buffer write");
   a_space_len: assert property (tx_on && edge_seen && lvl |-> (run % per) == 17'h00000)
      else $error("space run not a whole number of bit periods");
   a_mark_idle: assert property ((!c.sync_mode && !c.transmit_enable && $stable(c))[*3] |-> lvl)
      else $error("idle line not at mark");
   a_clock_quiet: assert property ((quiet && $stable(c))[*3] |-> !lvl)
      else $error("receive clock not at idle level");
   a_clock_high: assert property (rx_on && edge_seen && !transmit_clock_pin_o |-> run == per)
      else $error("receive clock high phase has wrong length");
   a_err_map: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > `SAT_OFF_DIV))
      else $error("error response does not match address map");

   c_frame: cover property (tx_on && edge_seen && !lvl);
   c_rx_clock: cover property (rx_on && edge_seen);
   c_request: cover property ($rose(transmit_request));
endmodule

bind sat_core sat_sva u_sva (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .transmit_clock_pin_o(transmit_clock_pin_o), .transmit_clock_pin_oe(transmit_clock_pin_oe),
   .receive_data_pin_i(receive_data_pin_i), .receive_data_pin_o(receive_data_pin_o),
   .receive_data_pin_oe(receive_data_pin_oe), .transmit_request(transmit_request)
);

// >>> dv/sat_peer.sv
`timescale 1ns/10ps

// Remote sender: drives the next bit after each leading clock edge.
module sat_peer (
   input  wire logic       pclk,
   input  wire logic       act,
   input  wire logic       slow,
   input  wire logic [7:0] word,
   input  wire logic       clk_pin,
   output logic            data
);
   logic       clk_d = 1'b0;
   logic       due   = 1'b0;
   logic [2:0] idx   = 3'h0;
   initial data = 1'b0;
   always @(posedge pclk) begin
      clk_d <= clk_pin;
      due   <= act && clk_pin && !clk_d;
      if (!act) begin
         idx  <= 3'h0;
         data <= ~data; // A released line must not look like a held bit.
      end else if (slow ? due : (clk_pin && !clk_d)) begin
         data <= word[idx];
         idx  <= idx + 3'h1;
      end
   end
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/10ps
`include "sat_cfg.svh"

module tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pin;
   logic        pin_oe;
   logic        rx_in;
   logic        tx_req;
   logic        act = 1'b0;
   logic        slow = 1'b0;
   logic [7:0]  word = 8'h00;
   logic        pol = 1'b0;
   logic        mon_on = 1'b0;
   logic        want_start = 1'b0;
   logic [9:0]  fr;
   logic        ok;
   logic [31:0] rd_data;
   logic        rd_err;
   logic [7:0]  exp_q[$];
   int          miscompares = 0;
   int          check_count = 0;

   always #10 pclk = ~pclk;

   sat_core #(.FIFO_DEPTH(2), .DIV_WIDTH(16)) uut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .transmit_clock_pin_o(pin), .transmit_clock_pin_oe(pin_oe), .receive_data_pin_i(rx_in),
      .receive_data_pin_o(), .receive_data_pin_oe(), .transmit_request(tx_req)
   );
   sat_peer u_peer (.pclk(pclk), .act(act), .slow(slow), .word(word), .clk_pin(pin), .data(rx_in));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic poll(input int b);
      int n;
      n = 0;
      do begin
         apb(1'b0, `SAT_OFF_STATUS, 32'h0);
         n++;
      end while (rd_data[b] !== 1'b1 && n < 200);
      check("status bit", rd_data[b], 1'b1);
   endtask

   task automatic drain();
      while (exp_q.size() > 0) @(posedge pclk);
      repeat (4) @(posedge pclk);
   endtask

   task automatic peer_restart(input logic s);
      act <= 1'b0;
      repeat (2) @(posedge pclk);
      word <= $urandom;
      act  <= 1'b1;
      slow <= s;
   endtask

   always begin
      @(posedge pclk);
      if (want_start) check("no gap", pin ^ pol, 1'b0);
      want_start = 1'b0;
      if (mon_on && (pin ^ pol) === 1'b0) begin
         ok = 1'b1;
         for (int b = 0; b < 10; b++) begin
            for (int c = 0; c < 2; c++) begin
               if (b > 0 || c > 0) @(posedge pclk);
               if (c == 0) fr[b] = pin ^ pol;
               else if ((pin ^ pol) !== fr[b]) ok = 1'b0;
            end
         end
         check("bit length", ok, 1'b1);
         check("start stop", {fr[9], fr[0]}, 2'b10);
         if (exp_q.size() == 0) check("spurious frame", 1'b1, 1'b0);
         else check("character", fr[8:1], exp_q.pop_front());
         want_start = exp_q.size() > 0;
      end
   end

   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      $display("CHECK FAILED watchdog expected finish seen hang");
      end_sim();
   end

   initial begin
      int a;
      void'($urandom(52438));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("idle pin", pin, 1'b1);
      check("pin enable", pin_oe, 1'b0);
      apb(1'b0, `SAT_OFF_CTRL, 32'h0);
      check("ctrl reset", rd_data, 32'h0);
      apb(1'b0, `SAT_OFF_DIV, 32'h0);
      check("div reset", rd_data, `SAT_DIV_RESET);
      apb(1'b0, `SAT_OFF_STATUS, 32'h0);
      check("flag reset", rd_data[0], 1'b0);
      apb(1'b0, 12'h020, 32'h0);
      check("unmapped error", rd_err, 1'b1);
      check("unmapped data", rd_data, 32'h0);
      apb(1'b1, `SAT_OFF_DIV, 32'h0000FF01);
      apb(1'b1, `SAT_OFF_CTRL, 32'h00000103);
      apb(1'b0, `SAT_OFF_STATUS, 32'h0);
      check("flag on enable", rd_data[0], 1'b1);
      check("pin enable", pin_oe, 1'b1);
      check("request", tx_req, 1'b1);
      for (int p = 0; p < 2; p++) begin
         mon_on = 1'b0;
         pol    = p[0];
         apb(1'b1, `SAT_OFF_CTRL, {23'h000000, 4'h8, p[0], 4'h1});
         apb(1'b1, `SAT_OFF_CTRL, {23'h000000, 4'h8, p[0], 4'h3});
         mon_on = 1'b1;
         for (int k = 0; k < 2; k++) begin
            a = $urandom;
            exp_q.push_back(a[7:0]);
            apb(1'b1, `SAT_OFF_TXBUF, {24'h000000, a[7:0]});
         end
         @(posedge pclk);
         apb(1'b0, `SAT_OFF_STATUS, 32'h0);
         check("flag busy", rd_data[0], 1'b0);
         check("request busy", tx_req, 1'b0);
         drain();
         apb(1'b0, `SAT_OFF_STATUS, 32'h0);
         check("flag drained", rd_data[0], 1'b1);
      end
      mon_on = 1'b0;
      pol    = 1'b0;
      apb(1'b1, `SAT_OFF_CTRL, 32'h00000002);
      repeat (2) @(posedge pclk);
      mon_on = 1'b1;
      a = $urandom;
      apb(1'b1, `SAT_OFF_TXBUF, {24'h000000, a[7:0]});
      repeat (30) begin
         @(posedge pclk);
         check("held without port", pin, 1'b1);
      end
      exp_q.push_back(a[7:0]);
      apb(1'b1, `SAT_OFF_CTRL, 32'h00000003);
      drain();
      mon_on = 1'b0;
      apb(1'b1, `SAT_OFF_DIV, 32'h00000003);
      apb(1'b1, `SAT_OFF_CTRL, 32'h00000085);
      peer_restart(1'b0);
      apb(1'b1, `SAT_OFF_CTRL, 32'h000000A7);
      poll(`SAT_ST_RXFLAG);
      apb(1'b0, `SAT_OFF_CTRL, 32'h0);
      check("single clears", rd_data, 32'h00000087);
      apb(1'b0, `SAT_OFF_RXBUF, 32'h0);
      check("single char", rd_data[7:0], word);
      peer_restart(1'b1);
      apb(1'b1, `SAT_OFF_CTRL, 32'h000000C5);
      poll(`SAT_ST_RXFULL);
      apb(1'b1, `SAT_OFF_CTRL, 32'h00000085);
      repeat (2) begin
         apb(1'b0, `SAT_OFF_RXBUF, 32'h0);
         check("fifo char", rd_data[7:0], word);
      end
      apb(1'b0, `SAT_OFF_STATUS, 32'h0);
      check("flag empty", rd_data[`SAT_ST_RXFLAG], 1'b0);
      peer_restart(1'b0);
      apb(1'b1, `SAT_OFF_CTRL, 32'h000000AD);
      poll(`SAT_ST_RXFLAG);
      apb(1'b0, `SAT_OFF_RXBUF, 32'h0);
      check("after discard", rd_data[7:0], word);
      end_sim();
   end
endmodule
